// *** src/pbs_pkg.sv ***
package pbs_pkg;

  // Sequencer time base.
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned RESET_TIME_MS   = 260;
  localparam int unsigned RESET_CYCLES    = (CLK_HZ / 1000) * RESET_TIME_MS;
  localparam int unsigned DEBOUNCE_TIME_US = 20;
  localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1_000_000) * DEBOUNCE_TIME_US;
  localparam int unsigned TIMER_W         = 32;
  localparam int unsigned DEB_W           = 16;

  // Inputs that pass through the debouncer, one bit each.
  localparam int unsigned NUM_FILTERED = 7;
  localparam int unsigned IDX_BUTTON   = 0;
  localparam int unsigned IDX_HARD     = 1;
  localparam int unsigned IDX_CHARGER  = 2;
  localparam int unsigned IDX_EN_LO    = 3;
  localparam int unsigned NUM_CHANNELS = 4;

  // Factory variant selection.
  typedef enum logic
  {
    PBS_VARIANT_B,
    PBS_VARIANT_C
  } pbs_variant_t;

  // Regulator enable bits, channel 1 in bit 0.
  localparam logic [3:0] REG_NONE    = 4'h0;
  localparam logic [3:0] REG_1_ONLY  = 4'h1;
  localparam logic [3:0] REG_1_TO_3  = 4'h7;

  // Sequencer states.
  typedef enum logic [2:0]
  {
    ST_OFF,
    ST_RAMP,
    ST_RESET_HOLD,
    ST_WAIT_HOST,
    ST_RUN
  } pbs_state_t;

  // Filtered view of the pins.
  typedef struct packed
  {
    logic       button;
    logic       hard_reset;
    logic       charger_ok;
    logic [3:0] channel_en;
  } pbs_inputs_t;

endpackage : pbs_pkg

// *** src/pbs_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none

module pbs_debounce
  import pbs_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    ce_i,
  input  wire logic [NUM_FILTERED-1:0] raw_i,
  output logic      [NUM_FILTERED-1:0] clean_o
);

  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES - 1);

  // Each bit is synchronised in two flops, then must stay stable for the
  // whole debounce time before the clean copy follows it.
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERED; g++)
    begin : g_bit
      logic             meta;
      logic             sync;
      logic             clean;
      logic [DEB_W-1:0] cnt;
      logic             next_clean;
      logic [DEB_W-1:0] next_cnt;

      // Count while the synchronised level differs from the clean one.
      always_comb
      begin
        next_clean = clean;
        next_cnt   = '0;
        if (sync != clean)
        begin
          if (cnt == DEB_LAST)
          begin
            next_clean = sync;
          end
          else
          begin
            next_cnt = cnt + DEB_W'(1);
          end
        end
      end

      // Registers; meta is read by sync alone.
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
        begin
          meta  <= 1'b0;
          sync  <= 1'b0;
          clean <= 1'b0;
          cnt   <= '0;
        end
        else if (ce_i)
        begin
          meta  <= raw_i[g];
          sync  <= meta;
          clean <= next_clean;
          cnt   <= next_cnt;
        end
      end

      assign clean_o[g] = clean;
    end
  endgenerate

endmodule // pbs_debounce

`default_nettype wire

// *** src/pbs_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter pbs_variant_t       VARIANT      = PBS_VARIANT_B,
  parameter int unsigned        RESET_PERIOD = RESET_CYCLES
)
(
  input  wire logic       MCLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       CE_I,
  input  wire logic       POWER_BUTTON_IN_N_I,
  input  wire logic       POWER_BUTTON_HARD_N_I,
  input  wire logic       CHARGER_INPUT_VALID_I,
  input  wire logic [3:0] CHANNEL_ENABLE_I,
  input  wire logic       REGULATOR_1_GOOD_I,
  input  wire logic       REGULATOR_1_WITHIN_TOL_I,
  input  wire logic       FAULT_I,
  input  wire logic       FAULT_POLL_I,
  output logic      [3:0] REGULATOR_ENABLE_O,
  output logic            SYS_RESET_OUT_N_O,
  output logic            SYS_RESET_OUT_OE_O,
  output logic            INTERRUPT_OUT_N_O,
  output logic            INTERRUPT_OUT_OE_O,
  output logic            SYSTEM_ON_O
);

  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(RESET_PERIOD - 1);

  pbs_inputs_t               in_f;
  logic [NUM_FILTERED-1:0]   raw;
  logic [NUM_FILTERED-1:0]   clean;

  pbs_state_t                state;
  pbs_state_t                next_state;
  logic [TIMER_W-1:0]        timer;
  logic [TIMER_W-1:0]        next_timer;
  logic [3:0]                reg_en;
  logic [3:0]                next_reg_en;
  logic                      rst_low;
  logic                      next_rst_low;
  logic                      hard_timer_run;
  logic                      next_hard_timer_run;
  logic [TIMER_W-1:0]        hard_timer;
  logic [TIMER_W-1:0]        next_hard_timer;
  logic                      fault_flag;
  logic                      next_fault_flag;
  logic                      irq_low;
  logic                      next_irq_low;
  logic                      sys_on;
  logic                      next_sys_on;

  // Start set and startup regulators follow the strap parameter.
  function automatic logic [3:0] startup_regs(input pbs_variant_t v);
    return (v == PBS_VARIANT_C) ? REG_1_ONLY : REG_1_TO_3;
  endfunction

  // Presence of a start or hold condition: button, or charger in variant C.
  function automatic logic hold_source(input pbs_inputs_t f, input pbs_variant_t v);
    return f.button | ((v == PBS_VARIANT_C) & f.charger_ok);
  endfunction

  // Pins are active low for the button and the hard reset; flip to active-high before filtering.
  assign raw[IDX_BUTTON]  = ~POWER_BUTTON_IN_N_I;
  assign raw[IDX_HARD]    = ~POWER_BUTTON_HARD_N_I;
  assign raw[IDX_CHARGER] = CHARGER_INPUT_VALID_I;
  assign raw[IDX_EN_LO +: NUM_CHANNELS] = CHANNEL_ENABLE_I;

  // The button, hard-reset, charger and channel-enable pins pass the filter before the state machine.
  pbs_debounce u_debounce
  (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .raw_i   (raw),
    .clean_o (clean)
  );

  assign in_f.button     = clean[IDX_BUTTON];
  assign in_f.hard_reset = clean[IDX_HARD];
  assign in_f.charger_ok = clean[IDX_CHARGER];
  assign in_f.channel_en = clean[IDX_EN_LO +: NUM_CHANNELS];

  // Main startup and shutdown sequencing.
  always_comb
  begin
    next_state  = state;
    next_timer  = timer;
    next_reg_en = reg_en;
    next_rst_low = rst_low;
    next_sys_on = sys_on;
    case (state)
      ST_OFF:
      begin
        next_reg_en  = REG_NONE;
        next_rst_low = 1'b1;
        next_sys_on  = 1'b0;
        if (hold_source(in_f, VARIANT))
        begin
          next_state  = ST_RAMP;
          next_reg_en = startup_regs(VARIANT);
          next_sys_on = 1'b1;
        end
      end
      ST_RAMP:
      begin
        if (!hold_source(in_f, VARIANT) && (in_f.channel_en == REG_NONE))
        begin
          next_state = ST_OFF;
        end
        else if (REGULATOR_1_GOOD_I)
        begin
          next_state   = ST_RESET_HOLD;
          next_timer   = '0;
          next_rst_low = 1'b1;
        end
      end
      ST_RESET_HOLD:
      begin
        // Reset stays low past expiry while regulator 1 is out of window.
        if (!hold_source(in_f, VARIANT) && (in_f.channel_en == REG_NONE))
        begin
          next_state = ST_OFF;
        end
        else if (timer != TIMER_LAST)
        begin
          next_timer = timer + TIMER_W'(1);
        end
        else if (REGULATOR_1_WITHIN_TOL_I)
        begin
          next_rst_low = 1'b0;
          next_state   = ST_WAIT_HOST;
        end
      end
      ST_WAIT_HOST:
      begin
        // Host must take over before the hold source goes away.
        if (in_f.channel_en != REG_NONE)
        begin
          next_state = ST_RUN;
        end
        else if (!hold_source(in_f, VARIANT))
        begin
          next_state = ST_OFF;
        end
      end
      ST_RUN:
      begin
        // Host owns each regulator; order of disabling is its business.
        next_reg_en = in_f.channel_en;
        if (in_f.channel_en == REG_NONE)
        begin
          next_state   = ST_OFF;
          next_rst_low = 1'b1;
          next_sys_on  = 1'b0;
        end
      end
      default:
      begin
        next_state = ST_OFF;
      end
    endcase
    // Before the host takes over, its enables add channels to the start set.
    if ((state == ST_RAMP || state == ST_RESET_HOLD || state == ST_WAIT_HOST)
        && (next_state != ST_OFF))
    begin
      next_reg_en = startup_regs(VARIANT) | in_f.channel_en;
    end
    if (next_state == ST_OFF)
    begin
      next_reg_en = REG_NONE;
      next_sys_on = 1'b0;
      next_rst_low = 1'b1;
    end
  end

  // Hard reset: low at once while pulled, then a full timeout after release.
  always_comb
  begin
    next_hard_timer_run = hard_timer_run;
    next_hard_timer     = hard_timer;
    if (in_f.hard_reset)
    begin
      next_hard_timer_run = 1'b1;
      next_hard_timer     = '0;
    end
    else if (hard_timer_run)
    begin
      if (hard_timer == TIMER_LAST)
      begin
        next_hard_timer_run = 1'b0;
      end
      else
      begin
        next_hard_timer = hard_timer + TIMER_W'(1);
      end
    end
  end

  // Interrupt: button level while running, plus a fault flag held until polled.
  always_comb
  begin
    next_fault_flag = fault_flag;
    if (FAULT_POLL_I)
    begin
      next_fault_flag = 1'b0;
    end
    if (FAULT_I)
    begin
      next_fault_flag = 1'b1; // Set wins over the poll clear.
    end
    next_irq_low = ((state == ST_RUN) && in_f.button) || next_fault_flag;
  end

  // State registers; the clock enable freezes everything.
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      state          <= ST_OFF;
      timer          <= '0;
      reg_en         <= REG_NONE;
      rst_low        <= 1'b1;
      sys_on         <= 1'b0;
      hard_timer_run <= 1'b0;
      hard_timer     <= '0;
      fault_flag     <= 1'b0;
      irq_low        <= 1'b0;
    end
    else if (CE_I)
    begin
      state          <= next_state;
      timer          <= next_timer;
      reg_en         <= next_reg_en;
      rst_low        <= next_rst_low;
      sys_on         <= next_sys_on;
      hard_timer_run <= next_hard_timer_run;
      hard_timer     <= next_hard_timer;
      fault_flag     <= next_fault_flag;
      irq_low        <= next_irq_low;
    end
  end

  // Output flops; open-drain pins drive low only, enable high while pulling.
  logic [3:0] reg_en_q;
  logic       rst_oe_q;
  logic       next_rst_oe;
  logic       sys_on_q;

  // The reset pin is pulled by the sequencer or by the hard-reset timeout.
  assign next_rst_oe = next_rst_low | next_hard_timer_run;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      reg_en_q <= REG_NONE;
      rst_oe_q <= 1'b1;
      sys_on_q <= 1'b0;
    end
    else if (CE_I)
    begin
      reg_en_q <= next_reg_en;
      rst_oe_q <= next_rst_oe;
      sys_on_q <= next_sys_on;
    end
  end

  assign REGULATOR_ENABLE_O = reg_en_q;
  assign SYS_RESET_OUT_N_O  = 1'b0;
  assign SYS_RESET_OUT_OE_O = rst_oe_q;
  assign INTERRUPT_OUT_N_O  = 1'b0;
  assign INTERRUPT_OUT_OE_O = irq_low; // The interrupt state flop drives the pin directly.
  assign SYSTEM_ON_O        = sys_on_q;

endmodule // pbs_sequencer

`default_nettype wire

// *** verification/pbs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pbs_host_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       rst_oe_i,
  input  wire logic       irq_oe_i,
  input  wire logic [3:0] want_i,
  input  wire logic       svc_i,
  output logic      [3:0] en_o
);
  logic        down;
  logic [10:0] tick;

  // Steps are spaced past the input filter so each drop is seen alone.
  always_ff @(posedge clk_i)
  begin
    tick <= tick + 11'h001;
    if (!rst_n_i)
    begin
      en_o <= 4'h0;
      down <= 1'b0;
      tick <= 11'h000;
    end
    else if (down)
    begin
      if (tick == 11'h44C)
      begin
        en_o <= en_o & (en_o - 4'h1);
        down <= |(en_o & (en_o - 4'h1));
        tick <= 11'h000;
      end
    end
    else if (svc_i && irq_oe_i) // Charger is absent here.
    begin
      down <= 1'b1;
      tick <= 11'h000;
    end
    else if (!rst_oe_i)
      en_o <= want_i; // Only a running processor drives its enables.
  end
endmodule // pbs_host_model
`default_nettype wire

// *** verification/pbs_sequencer_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module pbs_sequencer_chk
  import pbs_pkg::*;
#(
  parameter pbs_variant_t VARIANT      = PBS_VARIANT_B,
  parameter int unsigned  RESET_PERIOD = RESET_CYCLES
)
(
  input wire logic       MCLK_I,
  input wire logic       RST_N_I,
  input wire logic       CE_I,
  input wire logic       REGULATOR_1_WITHIN_TOL_I,
  input wire logic [3:0] REGULATOR_ENABLE_O,
  input wire logic       SYS_RESET_OUT_N_O,
  input wire logic       SYS_RESET_OUT_OE_O,
  input wire logic       INTERRUPT_OUT_N_O,
  input wire logic       INTERRUPT_OUT_OE_O,
  input wire logic       SYSTEM_ON_O
);
  localparam logic [3:0] START = (VARIANT == PBS_VARIANT_B) ? REG_1_TO_3 : REG_1_ONLY;
  int unsigned held;
  int unsigned next_held;

  // Reset hold length; it freezes with CE_I just as the device timer does.
  always_comb
  begin
    next_held = held;
    if (!SYS_RESET_OUT_OE_O)
      next_held = 0;
    else if (CE_I)
      next_held = held + 1;
  end

  always_ff @(posedge MCLK_I)
    held <= next_held;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence reset_drop;
    SYS_RESET_OUT_OE_O ##1 !SYS_RESET_OUT_OE_O;
  endsequence

  off_quiet_a:
    assert property (!SYSTEM_ON_O |-> REGULATOR_ENABLE_O == REG_NONE && SYS_RESET_OUT_OE_O)
    else $error("rails or reset wrong while off");
  pins_low_a:
    assert property (SYS_RESET_OUT_N_O == 1'b0 && INTERRUPT_OUT_N_O == 1'b0)
    else $error("open drain data not low");
  on_has_rail_a:
    assert property (SYSTEM_ON_O |-> REGULATOR_ENABLE_O != REG_NONE)
    else $error("on with no rail");
  start_set_a:
    assert property ($rose(SYSTEM_ON_O) |-> (REGULATOR_ENABLE_O & START) == START)
    else $error("wrong startup rails");
  hold_span_a:
    assert property (reset_drop |-> held >= RESET_PERIOD)
    else $error("reset released early");
  tol_release_a:
    assert property (reset_drop |-> $past(REGULATOR_1_WITHIN_TOL_I) || !SYSTEM_ON_O)
    else $error("reset released out of tolerance");
  ce_freeze_a:
    assert property (!CE_I |=> $stable(REGULATOR_ENABLE_O) && $stable(SYSTEM_ON_O)
                     && $stable(SYS_RESET_OUT_OE_O))
    else $error("state moved with clock enable low");
  irq_on_a:
    assert property ($rose(INTERRUPT_OUT_OE_O) |-> SYSTEM_ON_O)
    else $error("interrupt while off");
endmodule // pbs_sequencer_chk
`default_nettype wire

// *** verification/pbs_sequencer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
  comparisons++; \
  if ((got) !== (exp)) \
  begin \
    err_count++; \
    $display("[FAIL] %s exp %0h got %0h", name, exp, got); \
  end

module pbs_sequencer_bench
  import pbs_pkg::*;
;
  localparam int unsigned RP = 20;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic       btn_n = 1'b1;
  logic       hard_n = 1'b1;
  logic       chg = 1'b0;
  logic       good = 1'b0;
  logic       tol = 1'b1;
  logic       fault = 1'b0;
  logic       poll = 1'b0;
  logic       svc = 1'b0;
  logic [3:0] want = 4'h0;
  logic [3:0] en;
  logic [3:0] reg_b;
  logic [3:0] reg_c;
  logic       oe_b;
  logic       irq_b;
  logic       on_b;
  logic       on_c;
  int         err_count = 0;
  int         comparisons = 0;
  // Host request in the high nibble, expected rails in the low one.
  logic [7:0] rows [6] = '{8'h22, 8'h44, 8'h88, 8'h55, 8'hFF, 8'h11};

  always #10 clk = ~clk;

  pbs_sequencer #(.VARIANT(PBS_VARIANT_B), .RESET_PERIOD(RP)) u_dut (
    .MCLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .POWER_BUTTON_IN_N_I(btn_n),
    .POWER_BUTTON_HARD_N_I(hard_n), .CHARGER_INPUT_VALID_I(chg), .CHANNEL_ENABLE_I(en),
    .REGULATOR_1_GOOD_I(good), .REGULATOR_1_WITHIN_TOL_I(tol), .FAULT_I(fault),
    .FAULT_POLL_I(poll), .REGULATOR_ENABLE_O(reg_b), .SYS_RESET_OUT_N_O(),
    .SYS_RESET_OUT_OE_O(oe_b), .INTERRUPT_OUT_N_O(), .INTERRUPT_OUT_OE_O(irq_b),
    .SYSTEM_ON_O(on_b));

  pbs_sequencer #(.VARIANT(PBS_VARIANT_C), .RESET_PERIOD(RP)) u_dut_c (
    .MCLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .POWER_BUTTON_IN_N_I(btn_n),
    .POWER_BUTTON_HARD_N_I(hard_n), .CHARGER_INPUT_VALID_I(chg), .CHANNEL_ENABLE_I(en),
    .REGULATOR_1_GOOD_I(good), .REGULATOR_1_WITHIN_TOL_I(tol), .FAULT_I(fault),
    .FAULT_POLL_I(poll), .REGULATOR_ENABLE_O(reg_c), .SYS_RESET_OUT_N_O(),
    .SYS_RESET_OUT_OE_O(), .INTERRUPT_OUT_N_O(), .INTERRUPT_OUT_OE_O(),
    .SYSTEM_ON_O(on_c));

  pbs_host_model u_host (.clk_i(clk), .rst_n_i(rst_n), .rst_oe_i(oe_b),
    .irq_oe_i(irq_b), .want_i(want), .svc_i(svc), .en_o(en));

  // Waits end on the falling edge so registered outputs have settled.
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Every change on a filtered pin needs about 1003 cycles to pass the filter.
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    w(2);
    `CHK("oe_b", 1'b1, oe_b)
    // A press shorter than the filter time must leave the system off.
    @(posedge clk) btn_n <= 1'b0;
    w(500);
    @(posedge clk) btn_n <= 1'b1;
    w(1100);
    `CHK("on_b", 1'b0, on_b)
    `CHK("on_c", 1'b0, on_c)
    @(posedge clk) btn_n <= 1'b0;
    w(1100);
    `CHK("reg_b", REG_1_TO_3, reg_b)
    `CHK("reg_c", REG_1_ONLY, reg_c)
    `CHK("oe_b", 1'b1, oe_b)
    @(posedge clk) btn_n <= 1'b1;
    w(1100);
    `CHK("on_b", 1'b0, on_b)
    `CHK("on_c", 1'b0, on_c)
    @(posedge clk) chg <= 1'b1;
    w(1100);
    `CHK("on_c", 1'b1, on_c)
    `CHK("on_b", 1'b0, on_b)
    @(posedge clk) chg <= 1'b0;
    w(1100);
    `CHK("on_c", 1'b0, on_c)
    @(posedge clk) btn_n <= 1'b0;
    w(1100);
    @(posedge clk)
    begin
      good <= 1'b1;
      tol <= 1'b0;
    end
    w(RP + 40);
    `CHK("oe_b", 1'b1, oe_b)
    // Freeze the clock enable across the release so the held reset must wait.
    @(posedge clk)
    begin
      tol <= 1'b1;
      ce <= 1'b0;
    end
    w(10);
    `CHK("oe_b", 1'b1, oe_b)
    @(posedge clk) ce <= 1'b1;
    w(10);
    `CHK("oe_b", 1'b0, oe_b)
    @(posedge clk) want <= 4'h1;
    w(1100);
    @(posedge clk) btn_n <= 1'b1;
    w(1100);
    `CHK("on_b", 1'b1, on_b)
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk) want <= rows[i][7:4];
      w(1100);
      `CHK("reg_b", rows[i][3:0], reg_b)
      `CHK("reg_c", rows[i][3:0], reg_c)
    end
    @(posedge clk) hard_n <= 1'b0;
    w(1100);
    `CHK("oe_b", 1'b1, oe_b)
    @(posedge clk) hard_n <= 1'b1;
    w(1010);
    `CHK("oe_b", 1'b1, oe_b)
    w(RP + 20);
    `CHK("oe_b", 1'b0, oe_b)
    @(posedge clk) ce <= 1'b0;
    w(5);
    @(posedge clk) ce <= 1'b1;
    @(posedge clk) fault <= 1'b1;
    @(posedge clk) fault <= 1'b0;
    w(20);
    `CHK("irq_b", 1'b1, irq_b)
    @(posedge clk) poll <= 1'b1;
    @(posedge clk) poll <= 1'b0;
    w(5);
    `CHK("irq_b", 1'b0, irq_b)
    @(posedge clk)
    begin
      svc <= 1'b1;
      btn_n <= 1'b0;
    end
    w(1100);
    `CHK("irq_b", 1'b1, irq_b)
    @(posedge clk)
    begin
      want <= 4'h0;
      btn_n <= 1'b1;
    end
    w(1100);
    `CHK("irq_b", 1'b0, irq_b)
    `CHK("on_b", 1'b1, on_b)
    w(1200);
    `CHK("on_b", 1'b0, on_b)
    `CHK("oe_b", 1'b1, oe_b)
    // Restart with regulator 1 already good and in window: reset spans RP cycles.
    @(posedge clk) btn_n <= 1'b0;
    w(1020);
    `CHK("oe_b", 1'b1, oe_b)
    `CHK("on_b", 1'b1, on_b)
    w(8);
    `CHK("oe_b", 1'b0, oe_b)
    results();
  end

  // About 23000 cycles are needed; the limit leaves ample margin.
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    results();
  end
endmodule // pbs_sequencer_bench

bind pbs_sequencer pbs_sequencer_chk #(.VARIANT(VARIANT), .RESET_PERIOD(RESET_PERIOD)) u_chk (.*);
`default_nettype wire
